// *** verilog/csos_pkg.sv ***
`default_nettype none
package csos_pkg;

	// Base clock and the millisecond tick that paces every timer
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned TICK_HZ = 1000;
	localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / TICK_HZ;
	localparam int unsigned MS_PER_S = 1000;

	// All timers count milliseconds; 22 bits cover the longest idle span
	typedef logic [21:0] csos_ms_t;

	// Shutter pulse widths
	localparam int unsigned PULSE_SHORT_MS_I = MS_PER_S / 4;
	localparam int unsigned PULSE_LONG_S = 1;
	localparam csos_ms_t PULSE_SHORT_MS = csos_ms_t'(PULSE_SHORT_MS_I);
	localparam csos_ms_t PULSE_LONG_MS = csos_ms_t'(PULSE_LONG_S * MS_PER_S);

	// Lockout after a pulse
	localparam int unsigned LOCK_SHORT_MS_I = MS_PER_S / 2;
	localparam int unsigned LOCK_LONG_S = 5;
	localparam csos_ms_t LOCK_SHORT_MS = csos_ms_t'(LOCK_SHORT_MS_I);
	localparam csos_ms_t LOCK_LONG_MS = csos_ms_t'(LOCK_LONG_S * MS_PER_S);

	// Pushbutton hold windows
	localparam int unsigned PB_POWER_S = 5;
	localparam int unsigned PB_MODE_MIN_S = 2;
	localparam int unsigned PB_MODE_MAX_S = 4;
	localparam csos_ms_t PB_POWER_MS = csos_ms_t'(PB_POWER_S * MS_PER_S);
	localparam csos_ms_t PB_MODE_MIN_MS = csos_ms_t'(PB_MODE_MIN_S * MS_PER_S);
	localparam csos_ms_t PB_MODE_MAX_MS = csos_ms_t'(PB_MODE_MAX_S * MS_PER_S);
	localparam csos_ms_t HOLD_MAX_MS = csos_ms_t'(PB_POWER_S * MS_PER_S + 1);
	localparam csos_ms_t SECOND_MS = csos_ms_t'(MS_PER_S);

	// Automatic power-off spans
	localparam int unsigned IDLE_TEST_MIN = 8;
	localparam int unsigned IDLE_RUN_MIN = 32;
	localparam csos_ms_t IDLE_TEST_MS = csos_ms_t'(IDLE_TEST_MIN * 60 * MS_PER_S);
	localparam csos_ms_t IDLE_RUN_MS = csos_ms_t'(IDLE_RUN_MIN * 60 * MS_PER_S);

	// LED status timing
	localparam int unsigned BLINK_TEST_S = 4;
	localparam int unsigned BLINK_RUN_S = 8;
	localparam csos_ms_t BLINK_TEST_MS = csos_ms_t'(BLINK_TEST_S * MS_PER_S);
	localparam csos_ms_t BLINK_RUN_MS = csos_ms_t'(BLINK_RUN_S * MS_PER_S);
	localparam csos_ms_t LED_BRIEF_MS = csos_ms_t'(50);
	localparam csos_ms_t LED_GAP_MS = csos_ms_t'(250);
	localparam csos_ms_t LED_LONG_MS = csos_ms_t'(1000);
	localparam csos_ms_t TIMER_LAST = csos_ms_t'(1);

	// Pushbutton debounce and power-on reset stretch
	localparam logic [4:0] DEBOUNCE_LAST = 5'h13;
	localparam logic [3:0] POR_DONE = 4'hF;

	// Wishbone register map
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam int unsigned CTRL_OFF_BIT = 0;

	// Trigger cycle phases
	typedef enum logic [1:0] {PH_IDLE, PH_PULSE, PH_LOCK} csos_phase_e;

	function automatic csos_ms_t pulse_ms(input logic wide);
		return wide ? PULSE_LONG_MS : PULSE_SHORT_MS;
	endfunction

	function automatic csos_ms_t lock_ms(input logic long_dly);
		return long_dly ? LOCK_LONG_MS : LOCK_SHORT_MS;
	endfunction

endpackage
`default_nettype wire

// *** verilog/csos_tick.sv ***
`default_nettype none
module csos_tick import csos_pkg::*; #(
	parameter int unsigned DIV = TICK_CYCLES_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic tick_o
);

	logic [31:0] cnt_q;

	// Divider: one-cycle enable every DIV clocks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 32'h0;
			tick_o <= 1'b0;
		end else if (cnt_q >= 32'(DIV - 1)) begin
			cnt_q <= 32'h0;
			tick_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick_o <= 1'b0;
		end
	end

endmodule // csos_tick
`default_nettype wire

// *** verilog/csos_debounce.sv ***
`default_nettype none
module csos_debounce import csos_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic raw_i,
	output logic level_o
);

	logic [4:0] cnt_q;

	// Level follows the input only after it has disagreed for 20 ticks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 5'h00;
			level_o <= 1'b0;
		end else if (raw_i == level_o) begin
			cnt_q <= 5'h00; // Any bounce back restarts the wait
		end else if (tick_i) begin
			if (cnt_q == DEBOUNCE_LAST) begin
				cnt_q <= 5'h00;
				level_o <= raw_i;
			end else begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

endmodule // csos_debounce
`default_nettype wire

// *** verilog/csos_top.sv ***
// Functional notes
// - Trigger low while powered and unlocked starts the shutter pulse immediately.
// - After the pulse, triggers are ignored until the lockout ends.
// - Lockout is 5 s with delay select high, 0.5 s when low.
// - Pulse is 0.25 s with width select low, 1 s when high.
// - Holding the pushbutton over 5 s toggles power.
// - Releasing after 2 to 4 s toggles run and test mode.
// - Every power-up lands in test mode.
// - While held with power on, the LED blinks briefly once per second.
// - A recognised power-on or mode command gives a long LED pulse; power-off gives none.
// - Test mode blocks the shutter and lights the LED instead.
// - Auto power-off after 8 min idle in test, 32 min in run.
// - Idle LED: double pulse every 4 s test, single every 8 s run.
// - Active shutter forces the LED off.
// - Internal power-on reset, no external reset needed.
`default_nettype none
module csos_top import csos_pkg::*; #(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic trigger_n_i,
	input wire logic delay_select_i,
	input wire logic width_select_i,
	input wire logic pushbutton_input_n_i,
	output logic shutter_o,
	output logic led_o,
	output logic power_o,
	output logic run_mode_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	logic [3:0] por_cnt_q = 4'h0;
	logic rst_q = 1'b1;
	logic tick;
	logic pb_held;
	logic pb_prev_q;
	csos_ms_t hold_q;
	csos_ms_t sec_q;
	csos_ms_t idle_q;
	csos_ms_t timer_q;
	csos_ms_t long_q;
	csos_ms_t blink_q;
	csos_phase_e phase_q;
	logic power_q;
	logic run_q;
	logic sw_off_q;
	logic start_w;
	logic pulse_end;
	logic pulse_on;
	logic shutter_d;
	logic led_d;
	logic power_evt;
	logic mode_evt;
	logic idle_evt;
	logic wb_req;
	logic brief_on;
	logic blink_on;
	csos_ms_t idle_limit;
	csos_ms_t blink_period;

	// Power-on reset: flop initial values hold reset for 16 clocks
	always_ff @(posedge clk_i) begin
		if (por_cnt_q != POR_DONE) begin
			por_cnt_q <= por_cnt_q + 4'h1;
		end
		rst_q <= rst_i || (por_cnt_q != POR_DONE);
	end

	csos_tick #(
		.DIV(TICK_CYCLES)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_q),
		.tick_o(tick)
	);

	// Pushbutton closes to ground; level is high while pressed
	csos_debounce u_pb (
		.clk_i(clk_i),
		.rst_i(rst_q),
		.tick_i(tick),
		.raw_i(~pushbutton_input_n_i),
		.level_o(pb_held)
	);

	// Pushbutton hold timing
	always_ff @(posedge clk_i) begin
		if (rst_q) begin
			pb_prev_q <= 1'b0;
			hold_q <= '0;
			sec_q <= '0;
		end else begin
			pb_prev_q <= pb_held;
			if (!pb_held) begin
				hold_q <= '0;
				sec_q <= '0;
			end else if (tick) begin
				if (hold_q != HOLD_MAX_MS) begin
					hold_q <= hold_q + TIMER_LAST;
				end
				sec_q <= (sec_q == SECOND_MS - TIMER_LAST) ? '0 : sec_q + TIMER_LAST;
			end
		end
	end

	// Commands: power fires the moment 5 s is exceeded, mode on release
	assign power_evt = pb_held && tick && (hold_q == PB_POWER_MS);
	assign mode_evt = pb_prev_q && !pb_held && power_q
		&& (hold_q >= PB_MODE_MIN_MS) && (hold_q < PB_MODE_MAX_MS);
	assign idle_limit = run_q ? IDLE_RUN_MS : IDLE_TEST_MS;
	assign idle_evt = power_q && (idle_q >= idle_limit);

	// Soft power and mode; power-up always selects test mode
	always_ff @(posedge clk_i) begin
		if (rst_q) begin
			power_q <= 1'b0;
			run_q <= 1'b0;
		end else if (power_evt) begin
			power_q <= !power_q;
			run_q <= 1'b0;
		end else if (idle_evt || (power_q && sw_off_q)) begin
			power_q <= 1'b0;
		end else if (mode_evt) begin
			run_q <= !run_q;
		end
	end

	// Idle timer restarts on every accepted trigger
	always_ff @(posedge clk_i) begin
		if (rst_q || !power_q || start_w) begin
			idle_q <= '0;
		end else if (tick && !idle_evt) begin
			idle_q <= idle_q + TIMER_LAST;
		end
	end

	// Trigger is level sensitive, so a held-low trigger re-fires after lockout
	assign start_w = power_q && (phase_q == PH_IDLE) && !trigger_n_i;
	assign pulse_end = (phase_q == PH_PULSE) && tick && (timer_q == TIMER_LAST);
	assign pulse_on = start_w || ((phase_q == PH_PULSE) && !pulse_end);

	// Trigger cycle: pulse, then lockout, then idle
	always_ff @(posedge clk_i) begin
		if (rst_q || !power_q) begin
			phase_q <= PH_IDLE;
			timer_q <= '0;
		end else begin
			case (phase_q)
				PH_IDLE: begin
					if (start_w) begin
						phase_q <= PH_PULSE;
						timer_q <= pulse_ms(width_select_i);
					end
				end
				PH_PULSE: begin
					if (pulse_end) begin
						phase_q <= PH_LOCK;
						timer_q <= lock_ms(delay_select_i);
					end else if (tick) begin
						timer_q <= timer_q - TIMER_LAST;
					end
				end
				PH_LOCK: begin
					if (tick) begin
						if (timer_q == TIMER_LAST) begin
							phase_q <= PH_IDLE;
						end else begin
							timer_q <= timer_q - TIMER_LAST;
						end
					end
				end
				default: begin
					phase_q <= PH_IDLE;
				end
			endcase
		end
	end

	// Long acknowledge pulse after a power-on or mode command
	always_ff @(posedge clk_i) begin
		if (rst_q) begin
			long_q <= '0;
		end else if (power_evt || mode_evt) begin
			long_q <= LED_LONG_MS;
		end else if (!power_q) begin
			long_q <= '0;
		end else if (tick && (long_q != '0)) begin
			long_q <= long_q - TIMER_LAST;
		end
	end

	// Idle blink period counter
	assign blink_period = run_q ? BLINK_RUN_MS : BLINK_TEST_MS;
	always_ff @(posedge clk_i) begin
		if (rst_q || !power_q) begin
			blink_q <= '0;
		end else if (tick) begin
			blink_q <= (blink_q >= blink_period - TIMER_LAST) ? '0 : blink_q + TIMER_LAST;
		end
	end

	// LED sources
	assign brief_on = pb_held && (hold_q >= SECOND_MS) && (sec_q < LED_BRIEF_MS);
	assign blink_on = (phase_q == PH_IDLE) && !pb_held && ((blink_q < LED_BRIEF_MS)
		|| (!run_q && (blink_q >= LED_GAP_MS) && (blink_q < LED_GAP_MS + LED_BRIEF_MS)));
	assign shutter_d = power_q && run_q && pulse_on;
	// Shutter blanks the LED so the LED never shows in the picture
	assign led_d = power_q && !shutter_d && ((long_q != '0) || brief_on || blink_on
		|| (!run_q && pulse_on));

	// Output registers
	always_ff @(posedge clk_i) begin
		if (rst_q) begin
			shutter_o <= 1'b0;
			led_o <= 1'b0;
		end else begin
			shutter_o <= shutter_d;
			led_o <= led_d;
		end
	end

	assign power_o = power_q;
	assign run_mode_o = run_q;

	// Wishbone slave: every access is acked one cycle after the request
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	always_ff @(posedge clk_i) begin
		if (rst_q) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			sw_off_q <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
			sw_off_q <= wb_req && wb_we_i && (wb_adr_i == ADDR_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_OFF_BIT];
			if (wb_req && !wb_we_i && (wb_adr_i == ADDR_STATUS)) begin
				wb_dat_o <= {27'h0, pb_held, phase_q, run_q, power_q};
			end else if (wb_req) begin
				wb_dat_o <= 32'h0000_0000; // Control and unmapped read as zero
			end
		end
	end

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_q);

	sequence s_pulse_last;
		(phase_q == PH_PULSE) && pulse_end;
	endsequence

	sequence s_lock_entered;
		(phase_q == PH_LOCK) ##0 (timer_q == lock_ms($past(delay_select_i)));
	endsequence

	chk_trig_starts: assert property (start_w |=> (phase_q == PH_PULSE) && (shutter_o == $past(run_q)))
		else $error("trigger did not start a pulse");
	chk_lock_ignores: assert property ((phase_q == PH_LOCK) && !trigger_n_i |=> (phase_q != PH_PULSE))
		else $error("trigger accepted during lockout");
	chk_lock_length: assert property (s_pulse_last |=> s_lock_entered)
		else $error("lockout length wrong");
	chk_pulse_width: assert property (start_w |=> timer_q == pulse_ms($past(width_select_i)))
		else $error("pulse width wrong");
	chk_power_toggle: assert property (power_evt |=> power_q != $past(power_q))
		else $error("power did not toggle");
	chk_mode_toggle: assert property (mode_evt && !idle_evt && !sw_off_q |=> run_q != $past(run_q))
		else $error("mode did not toggle");
	chk_powerup_test: assert property ($rose(power_q) |-> !run_q)
		else $error("power-up not in test mode");
	chk_ack_pulse: assert property (power_evt && !power_q |=> ##1 led_o)
		else $error("no long pulse after power-on");
	chk_test_blocks: assert property (start_w && !run_q |=> !shutter_o && led_o)
		else $error("test mode drove the shutter");
	chk_idle_off: assert property (idle_evt && !power_evt |=> !power_q)
		else $error("idle timeout ignored");
	chk_led_blank: assert property (shutter_o |-> !led_o)
		else $error("led lit during shutter");
	chk_off_quiet: assert property (!power_q |=> !shutter_o && !led_o)
		else $error("outputs active while off");
	// Every LED source reaches the pin while powered unless the shutter blanks it
	chk_brief_shown: assert property (brief_on && power_q && !shutter_d |=> led_o)
		else $error("hold blink missing");
	chk_idle_blink: assert property (blink_on && power_q && !shutter_d |=> led_o)
		else $error("idle blink missing");
	chk_test_lamp: assert property ((phase_q == PH_PULSE) && !run_q && power_q && !pulse_end |=> led_o)
		else $error("test pulse not on led");
	chk_lock_end: assert property ((phase_q == PH_LOCK) && tick && (timer_q == TIMER_LAST)
		|=> phase_q == PH_IDLE) else $error("lockout did not end");

endmodule // csos_top
`default_nettype wire

// *** verification/csos_partner.sv ***
`default_nettype none
// Trigger contact on the far side; an open contact reads high through its pull-up
module csos_partner (
	input wire logic clk_i,
	input wire logic close_i,
	output logic trigger_n_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Contact closes or opens on the edge after the bench asks, never mid-cycle
	initial trigger_n_o = 1'b1;
	always @(posedge clk_i) begin
		trigger_n_o <= ~close_i;
	end
endmodule // csos_partner
`default_nettype wire

// *** verification/csos_top_test.sv ***
`default_nettype none
module csos_top_test import csos_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICK = 4;
	localparam int LIMIT = 100000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic close_q = 1'b0;
	logic trigger_n;
	logic delay_sel = 1'b0;
	logic width_sel = 1'b0;
	logic pb_n = 1'b1;
	logic shutter, led, power, run_mode, ack;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, dat_o;
	logic led_prev = 1'b0;
	int led_rises = 0, fail_count = 0, cmp_count = 0, cycles = 0, n, ov, r;

	always #20 clk_i = ~clk_i;

	csos_partner u_partner (.clk_i(clk_i), .close_i(close_q), .trigger_n_o(trigger_n));
	csos_top #(.TICK_CYCLES(TICK)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .trigger_n_i(trigger_n),
		.delay_select_i(delay_sel), .width_select_i(width_sel), .pushbutton_input_n_i(pb_n),
		.shutter_o(shutter), .led_o(led), .power_o(power), .run_mode_o(run_mode),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));

	// LED rising edges, so a button hold can count its brief blinks
	always @(posedge clk_i) begin
		led_prev <= led;
		if (led === 1'b1 && led_prev === 1'b0) led_rises <= led_rises + 1;
	end

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// A hang counts as a mismatch and closes the run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	// Tick alignment makes long spans land within a few ticks of nominal
	task automatic chk_near(input string nm, input int exp, input int got, input int tol);
		cmp_count++;
		if (got < exp - tol || got > exp + tol) begin
			fail_count++;
			$display("[ERR] %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	// Classic single cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		// Only the bench timeout may end the wait for the answer
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// Hold the button a number of ticks, then release and let debounce settle
	task automatic hold_pb(input int ticks, output int rises);
		int r0;
		r0 = led_rises;
		pb_n <= 1'b0;
		repeat (ticks * TICK) @(posedge clk_i);
		rises = led_rises - r0;
		pb_n <= 1'b1;
		repeat (30 * TICK) @(posedge clk_i);
	endtask

	// Length of a run at one level, and cycles where shutter and LED overlap
	task automatic run_len(input logic use_led, input logic lvl, output int len, output int both);
		len = 0;
		both = 0;
		while ((use_led ? led : shutter) === lvl && len < 30000) begin
			@(posedge clk_i);
			len++;
			if (shutter === 1'b1 && led === 1'b1) both++;
		end
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("power", 0, power);
		close_q <= 1'b1;
		repeat (50) @(posedge clk_i);
		chk("shutter off", 0, {led, shutter});
		close_q <= 1'b0;
		wb(1'b0, ADDR_STATUS, 0, rdat);
		chk("status off", 0, rdat);
		wb(1'b0, 8'h08, 0, rdat);
		chk("unmapped", 0, rdat);
		hold_pb(5100, r);
		chk("power on", 1, power);
		chk("mode", 0, run_mode);
		// Unpowered the LED stays dark, so only the power-on long pulse rises
		chk("hold dark", 1, r);
		chk("long led", 1, led);
		repeat (1100 * TICK) @(posedge clk_i);
		close_q <= 1'b1;
		// Contact model adds one edge, the output register another
		repeat (3) @(posedge clk_i);
		chk("test trig", 2'b10, {led, shutter});
		close_q <= 1'b0;
		run_len(1'b1, 1'b1, n, ov);
		chk_near("test led", int'(PULSE_SHORT_MS) * TICK - 2, n, 3 * TICK);
		repeat (600 * TICK) @(posedge clk_i);
		hold_pb(3000, r);
		chk("hold blinks", 2, r);
		chk("mode run", 1, run_mode);
		chk("mode led", 1, led);
		repeat (1100 * TICK) @(posedge clk_i);
		wb(1'b0, ADDR_STATUS, 0, rdat);
		chk("status run", 32'h3, rdat);
		width_sel <= 1'b1;
		close_q <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("shutter", 1, shutter);
		// Trigger stays closed, so the next pulse marks the end of lockout
		run_len(1'b0, 1'b1, n, ov);
		chk_near("wide pulse", int'(PULSE_LONG_MS) * TICK - 2, n, 3 * TICK);
		chk("led blank", 0, ov);
		delay_sel <= 1'b1;
		run_len(1'b0, 1'b0, n, ov);
		chk_near("short lock", int'(LOCK_SHORT_MS) * TICK, n, 3 * TICK);
		run_len(1'b0, 1'b1, n, ov);
		run_len(1'b0, 1'b0, n, ov);
		chk_near("long lock", int'(LOCK_LONG_MS) * TICK, n, 3 * TICK);
		close_q <= 1'b0;
		wb(1'b1, ADDR_CTRL, 32'h1, rdat);
		repeat (3) @(posedge clk_i);
		chk("soft off", 0, {power, shutter, led});
		wb(1'b0, ADDR_CTRL, 0, rdat);
		chk("ctrl read", 0, rdat);
		print_verdict();
	end
endmodule // csos_top_test
`default_nettype wire
